/* File: hdl/fsal_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsal_consts.svh"

// How it works
// - Only in run, a period without rotation pulses counts toward failure.
// - Pulses in slot 0 of every drive period are blanked.
// - 32 periods with no pulse after the start-up retry force drive low and fault output low.
// - Fault stays latched until shutdown request toggles or power cycles.
// - Fault output is held high throughout shutdown.
// - Overheat alert goes low above high limit plus 10 C.
// - In run, drive stays at full duty while overheat alert is low.
// - Overheat alert releases only 5 C below its trip point.
// - Shutdown request low forces drive low and fault output high.
// - Temperature and overheat alert keep working during shutdown.
// - Auto-shutdown variant stops the fan below the low limit.
// - Overheat alert keeps working while auto-shutdown holds fan off.
// - Auto-shutdown exits only above the first step temperature.
// - Four step temperatures split low to high limit evenly.
// - Limits are 5 C multiples, span at least 10 C, low 25..35 C.
// - Duty runs 40% to 100% in 10% steps by region.
// - Drive runs near 15 Hz; its period times start-up and misses.
// - Drive is held high about 2 s whenever the fan starts from off.
// - First missing-pulse detection reruns start-up once before latching.
module fsal_top #(
  parameter int SLOT_CYCLES   = `FSAL_SLOT_CYCLES,
  parameter int LOW_LIMIT_C   = `FSAL_LOW_LIMIT_C,
  parameter int HIGH_LIMIT_C  = `FSAL_HIGH_LIMIT_C,
  parameter bit AUTO_SHUTDOWN = 1'b0
) (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  // Fan side
  input  wire logic              fan_off_request_n_in,
  input  wire logic              rotation_pulse_in,
  output logic                   pwm_out,
  // Sensor front end, same clock
  input  wire logic signed [7:0] temp_in,
  // Alerts
  output logic                   fault_n_out,
  output logic                   overheat_n_out
);

  localparam int SPAN    = HIGH_LIMIT_C - LOW_LIMIT_C;
  localparam int TRIP_C  = HIGH_LIMIT_C + `FSAL_OVH_OFFSET_C;
  localparam int REL_C   = TRIP_C - `FSAL_OVH_HYST_C;
  localparam int FIRST_C = LOW_LIMIT_C + SPAN / `FSAL_STEP_REGIONS;

  if ((LOW_LIMIT_C % `FSAL_LIMIT_STEP_C) != 0 ||
      (HIGH_LIMIT_C % `FSAL_LIMIT_STEP_C) != 0 ||
      SPAN < `FSAL_MIN_SPAN_C ||
      LOW_LIMIT_C < `FSAL_LOW_MIN_C ||
      LOW_LIMIT_C > `FSAL_LOW_MAX_C) begin : g_chk
    $error("fsal_top: temperature limits out of range");
  end

  fsal_pkg::fsal_tb_t    tb;
  fsal_pkg::fsal_state_t state_ff;
  fsal_pkg::fsal_state_t nxt_state;
  logic                  req_s1_ff;
  logic                  req_s2_ff;
  logic                  sen_s1_ff;
  logic                  sen_s2_ff;
  logic                  sen_d_ff;
  logic signed [7:0]     temp_ff;
  logic [4:0]            start_cnt_ff;
  logic [4:0]            nxt_start_cnt;
  logic [5:0]            miss_cnt_ff;
  logic [5:0]            nxt_miss_cnt;
  logic                  seen_ff;
  logic                  nxt_seen;
  logic                  retried_ff;
  logic                  nxt_retried;
  logic                  ovh_ff;
  logic                  nxt_ovh;
  logic [3:0]            duty_ff;
  logic [3:0]            nxt_duty;
  logic                  pwm_ff;
  logic                  nxt_pwm;
  logic                  fault_n_ff;
  logic                  ovh_n_ff;
  logic                  pulse_ok;
  logic                  had_pulse;
  int                    temp_c;

  fsal_timebase #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_timebase (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .tb_out    (tb)
  );

  // Edge search reads only the second stage of the pulse synchroniser
  assign pulse_ok  = sen_s2_ff && !sen_d_ff &&
                     (tb.slot != `FSAL_BLANK_SLOT);
  assign had_pulse = seen_ff || pulse_ok;
  assign temp_c    = int'(temp_ff);

  // Overheat with hysteresis, independent of fan state
  always_comb begin
    if (ovh_ff) begin
      nxt_ovh = temp_c > REL_C;
    end else begin
      nxt_ovh = temp_c > TRIP_C;
    end
  end

  // Duty region, latched once per period
  always_comb begin
    nxt_duty = duty_ff;
    if (tb.period_end) begin
      if (ovh_ff || temp_c >= HIGH_LIMIT_C) begin
        nxt_duty = `FSAL_DUTY_FULL;
      end else if (temp_c < LOW_LIMIT_C) begin
        nxt_duty = `FSAL_DUTY_MIN;
      end else begin
        nxt_duty = `FSAL_DUTY_LOW;
        for (int k = 1; k < `FSAL_STEP_REGIONS; k++) begin
          if (temp_c >= LOW_LIMIT_C + (k * SPAN) / `FSAL_STEP_REGIONS) begin
            nxt_duty = nxt_duty + 4'h1;
          end
        end
      end
    end
  end

  // Fan sequencing
  always_comb begin
    nxt_state     = state_ff;
    nxt_start_cnt = start_cnt_ff;
    nxt_miss_cnt  = miss_cnt_ff;
    nxt_retried   = retried_ff;
    // A pulse in the boundary cycle falls in blanked slot 0 and counts for neither period
    nxt_seen      = (seen_ff && !tb.period_end) || pulse_ok;
    if (!req_s2_ff) begin
      nxt_state = fsal_pkg::FSAL_FAN_OFF_REQUEST_N;
    end else begin
      case (state_ff)
        fsal_pkg::FSAL_FAN_OFF_REQUEST_N: begin
          nxt_state     = fsal_pkg::FSAL_START;
          nxt_start_cnt = '0;
          nxt_retried   = 1'b0;
        end
        fsal_pkg::FSAL_START, fsal_pkg::FSAL_RETRY: begin
          if (tb.period_end) begin
            if (start_cnt_ff == 5'(`FSAL_STARTUP_PERIODS - 1)) begin
              nxt_state    = fsal_pkg::FSAL_RUN;
              nxt_miss_cnt = '0;
            end else begin
              nxt_start_cnt = start_cnt_ff + 5'h01;
            end
          end
        end
        fsal_pkg::FSAL_RUN: begin
          if (tb.period_end) begin
            if (AUTO_SHUTDOWN && temp_c < LOW_LIMIT_C && !ovh_ff) begin
              nxt_state = fsal_pkg::FSAL_AUTO_OFF;
            end else if (had_pulse) begin
              nxt_miss_cnt = '0;
              nxt_retried  = 1'b0;
            end else if (miss_cnt_ff == 6'(`FSAL_MISS_PERIODS - 1)) begin
              if (retried_ff) begin
                nxt_state = fsal_pkg::FSAL_FAULT;
              end else begin
                nxt_state     = fsal_pkg::FSAL_RETRY;
                nxt_retried   = 1'b1;
                nxt_start_cnt = '0;
              end
            end else begin
              nxt_miss_cnt = miss_cnt_ff + 6'h01;
            end
          end
        end
        fsal_pkg::FSAL_AUTO_OFF: begin
          if (tb.period_end && temp_c > FIRST_C) begin
            nxt_state     = fsal_pkg::FSAL_START;
            nxt_start_cnt = '0;
          end
        end
        fsal_pkg::FSAL_FAULT: begin
          nxt_state = fsal_pkg::FSAL_FAULT;
        end
        default: begin
          nxt_state = fsal_pkg::FSAL_FAN_OFF_REQUEST_N;
        end
      endcase
    end
  end

  // Drive level follows the state being entered
  always_comb begin
    case (nxt_state)
      fsal_pkg::FSAL_START, fsal_pkg::FSAL_RETRY: begin
        nxt_pwm = 1'b1;
      end
      fsal_pkg::FSAL_RUN: begin
        nxt_pwm = nxt_ovh || (tb.slot < duty_ff);
      end
      default: begin
        nxt_pwm = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      req_s1_ff    <= 1'b1;
      req_s2_ff    <= 1'b1;
      sen_s1_ff    <= 1'b0;
      sen_s2_ff    <= 1'b0;
      sen_d_ff     <= 1'b0;
      temp_ff      <= '0;
      // Power-up is a start from off; the drive rises on the first edge
      state_ff     <= fsal_pkg::FSAL_FAN_OFF_REQUEST_N;
      start_cnt_ff <= '0;
      miss_cnt_ff  <= '0;
      seen_ff      <= 1'b0;
      retried_ff   <= 1'b0;
      ovh_ff       <= 1'b0;
      duty_ff      <= `FSAL_DUTY_MIN;
      pwm_ff       <= 1'b0;
      fault_n_ff   <= 1'b1;
      ovh_n_ff     <= 1'b1;
    end else begin
      req_s1_ff    <= fan_off_request_n_in;
      req_s2_ff    <= req_s1_ff;
      sen_s1_ff    <= rotation_pulse_in;
      sen_s2_ff    <= sen_s1_ff;
      sen_d_ff     <= sen_s2_ff;
      temp_ff      <= temp_in;
      state_ff     <= nxt_state;
      start_cnt_ff <= nxt_start_cnt;
      miss_cnt_ff  <= nxt_miss_cnt;
      seen_ff      <= nxt_seen;
      retried_ff   <= nxt_retried;
      ovh_ff       <= nxt_ovh;
      duty_ff      <= nxt_duty;
      pwm_ff       <= nxt_pwm;
      fault_n_ff   <= nxt_state != fsal_pkg::FSAL_FAULT;
      ovh_n_ff     <= !nxt_ovh;
    end
  end

  assign pwm_out        = pwm_ff;
  assign fault_n_out    = fault_n_ff;
  assign overheat_n_out = ovh_n_ff;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  a_fan_off_request_n_outputs: assert property (
    state_ff == fsal_pkg::FSAL_FAN_OFF_REQUEST_N |-> !pwm_out && fault_n_out)
    else $error("drive or fault active in shutdown");
  a_fan_off_request_n_fault_high: assert property (
    !req_s2_ff ##1 !req_s2_ff |=> fault_n_out)
    else $error("fault low while shutdown requested");
  a_fault_latched: assert property (
    state_ff == fsal_pkg::FSAL_FAULT && req_s2_ff
    |-> !fault_n_out && !pwm_out ##1 state_ff == fsal_pkg::FSAL_FAULT)
    else $error("fault not latched with drive low");
  a_fault_release: assert property (
    state_ff == fsal_pkg::FSAL_FAULT && !req_s2_ff
    |=> state_ff == fsal_pkg::FSAL_FAN_OFF_REQUEST_N ##1 fault_n_out)
    else $error("fault not released by shutdown request");
  a_ovh_trip: assert property (
    temp_ff > TRIP_C |=> !overheat_n_out)
    else $error("overheat alert missed above trip point");
  a_ovh_hyst: assert property (
    !overheat_n_out && temp_ff > REL_C |=> !overheat_n_out)
    else $error("overheat alert released inside hysteresis");
  a_ovh_full: assert property (
    !overheat_n_out && state_ff == fsal_pkg::FSAL_RUN |-> pwm_out)
    else $error("drive not full while overheat alert low");
  a_start_high: assert property (
    state_ff inside {fsal_pkg::FSAL_START, fsal_pkg::FSAL_RETRY}
    |-> pwm_out)
    else $error("drive low during start-up");
  a_auto_off: assert property (
    state_ff == fsal_pkg::FSAL_AUTO_OFF |-> !pwm_out)
    else $error("drive active in auto-shutdown");
  a_retry_once: assert property (
    $rose(state_ff == fsal_pkg::FSAL_FAULT) |-> $past(retried_ff))
    else $error("fault latched without start-up retry");
  a_blank_slot: assert property (
    sen_s2_ff && !sen_d_ff && tb.slot == `FSAL_BLANK_SLOT &&
    (!seen_ff || tb.period_end) |=> !seen_ff)
    else $error("pulse accepted inside blanking slot");

  c_fault: cover property (state_ff == fsal_pkg::FSAL_FAULT);
  c_overheat: cover property (!overheat_n_out ##1 overheat_n_out);
  c_retry_run: cover property (
    state_ff == fsal_pkg::FSAL_RETRY ##1 state_ff == fsal_pkg::FSAL_RUN);
  c_auto_off: cover property (state_ff == fsal_pkg::FSAL_AUTO_OFF);

endmodule
`default_nettype wire

/* File: hdl/fsal_consts.svh */
`ifndef FSAL_CONSTS_SVH
`define FSAL_CONSTS_SVH

// Clock and drive time base
`define FSAL_CLK_HZ          250000000
`define FSAL_PWM_FREQ_HZ     15
`define FSAL_DUTY_STEPS      10
`define FSAL_SLOT_CYCLES \
  (`FSAL_CLK_HZ / (`FSAL_PWM_FREQ_HZ * `FSAL_DUTY_STEPS))

// Start-up and missing-pulse timing, start-up given in ms, both used in drive periods
`define FSAL_STARTUP_MS      2000
`define FSAL_STARTUP_PERIODS ((`FSAL_STARTUP_MS * `FSAL_PWM_FREQ_HZ) / 1000)
`define FSAL_MISS_PERIODS    32

// Temperature limits in degrees C
`define FSAL_LOW_LIMIT_C     25
`define FSAL_HIGH_LIMIT_C    45
`define FSAL_LIMIT_STEP_C    5
`define FSAL_MIN_SPAN_C      10
`define FSAL_LOW_MIN_C       25
`define FSAL_LOW_MAX_C       35
`define FSAL_STEP_REGIONS    5
`define FSAL_OVH_OFFSET_C    10
`define FSAL_OVH_HYST_C      5

// Duty in tenths of a period
`define FSAL_DUTY_MIN        4'h4
`define FSAL_DUTY_LOW        4'h5
`define FSAL_DUTY_FULL       4'hA
`define FSAL_BLANK_SLOT      4'h0
`define FSAL_LAST_SLOT       4'h9

`endif

/* File: hdl/fsal_pkg.sv */
package fsal_pkg;

  typedef enum logic [2:0] {
    FSAL_FAN_OFF_REQUEST_N     = 3'h0,
    FSAL_START    = 3'h1,
    FSAL_RUN      = 3'h3,
    FSAL_RETRY    = 3'h2,
    FSAL_FAULT    = 3'h6,
    FSAL_AUTO_OFF = 3'h7
  } fsal_state_t;

  typedef struct packed {
    logic       period_end;
    logic [3:0] slot;
  } fsal_tb_t;

endpackage

/* File: hdl/fsal_timebase.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsal_consts.svh"

module fsal_timebase #(
  parameter int SLOT_CYCLES = `FSAL_SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  // Slot index and period boundary
  output fsal_pkg::fsal_tb_t    tb_out
);

  localparam int CW = (SLOT_CYCLES > 2) ? $clog2(SLOT_CYCLES) : 1;

  if (SLOT_CYCLES < 2) begin : g_chk
    $error("fsal_timebase: SLOT_CYCLES must be at least 2");
  end

  logic [CW-1:0]      cyc_ff;
  logic [CW-1:0]      nxt_cyc;
  fsal_pkg::fsal_tb_t tb_ff;
  fsal_pkg::fsal_tb_t nxt_tb;

  always_comb begin
    nxt_cyc           = cyc_ff + CW'(1);
    nxt_tb            = tb_ff;
    nxt_tb.period_end = 1'b0;
    if (cyc_ff == CW'(SLOT_CYCLES - 1)) begin
      nxt_cyc = '0;
      if (tb_ff.slot == `FSAL_LAST_SLOT) begin
        nxt_tb.slot       = 4'h0;
        nxt_tb.period_end = 1'b1;
      end else begin
        nxt_tb.slot = tb_ff.slot + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cyc_ff <= '0;
      tb_ff  <= '0;
    end else begin
      cyc_ff <= nxt_cyc;
      tb_ff  <= nxt_tb;
    end
  end

  assign tb_out = tb_ff;

endmodule
`default_nettype wire

/* File: sim/fsal_fan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsal_fan_model (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // Drive and rotor condition
  input  wire logic pwm_in,
  input  wire logic stalled_in,
  // Conditioned rotation pulse
  output logic      rotation_pulse_out
);
  logic [7:0] on_cnt_ff;

  // A stalled rotor still shows the turn-on spike, which must be blanked
  always_ff @(posedge mclk_in) begin
    if (!resetn_in || !pwm_in) begin
      on_cnt_ff          <= 8'h00;
      rotation_pulse_out <= 1'b0;
    end else begin
      if (on_cnt_ff != 8'hFF) begin
        on_cnt_ff <= on_cnt_ff + 8'h01;
      end
      rotation_pulse_out <= (on_cnt_ff == (stalled_in ? 8'h00 : 8'h14));
    end
  end
endmodule
`default_nettype wire

/* File: sim/fsal_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fsal_top_tb_top;
  localparam int SLOT = 8;
  localparam int PER  = 10 * SLOT;
  localparam int STEP = (45 - 25) / 5;
  logic              mclk_in   = 1'b0;
  logic              resetn_in = 1'b0;
  logic              req_n     = 1'b1;
  logic              stalled   = 1'b0;
  logic signed [7:0] temp      = 8'h14;
  logic              rot;
  logic              pwm;
  logic              pwm_a;
  logic              fault_a;
  logic              ovh_a;
  logic              fault_n;
  logic              ovh_n;
  logic [1:0]        exp_q[$];
  logic [1:0]        prev      = 2'h3;
  int                n_errors     = 0;
  int                total_checks = 0;

  always #2 mclk_in = ~mclk_in;

  fsal_top #(.SLOT_CYCLES(SLOT)) i_fsal_top (
    .mclk_in(mclk_in), .resetn_in(resetn_in),
    .fan_off_request_n_in(req_n), .rotation_pulse_in(rot),
    .pwm_out(pwm), .temp_in(temp),
    .fault_n_out(fault_n), .overheat_n_out(ovh_n));
  // Variant with auto-shutdown shares every input
  fsal_top #(.SLOT_CYCLES(SLOT), .AUTO_SHUTDOWN(1'b1)) i_fsal_top_auto (
    .mclk_in(mclk_in), .resetn_in(resetn_in),
    .fan_off_request_n_in(req_n), .rotation_pulse_in(rot),
    .pwm_out(pwm_a), .temp_in(temp),
    .fault_n_out(fault_a), .overheat_n_out(ovh_a));
  fsal_fan_model i_fsal_fan_model (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .pwm_in(pwm),
    .stalled_in(stalled), .rotation_pulse_out(rot));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic set_temp(input logic signed [7:0] v);
    @(posedge mclk_in);
    temp <= v;
  endtask

  task automatic measure(output logic [7:0] hi, output logic [7:0] hi_a);
    hi = 8'h00;
    hi_a = 8'h00;
    repeat (PER) begin
      @(negedge mclk_in);
      hi = hi + {7'h00, pwm};
      hi_a = hi_a + {7'h00, pwm_a};
    end
  endtask

  // Every alert change must match the oldest outstanding note
  always @(negedge mclk_in) begin
    if (resetn_in && {fault_n, ovh_n} !== prev) begin
      prev = {fault_n, ovh_n};
      if (exp_q.size() == 0) begin
        chk("alert change", 8'hFF, {6'h00, prev});
      end else begin
        chk("alerts", {6'h00, exp_q.pop_front()}, {6'h00, prev});
      end
    end
  end

  initial begin
    logic [7:0] hi;
    logic [7:0] hi_a;
    int         lim;
    int         base;
    void'($urandom(79097));
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(negedge mclk_in);
    chk("drive at release", 8'h00, pwm);
    for (int i = 0; i < 28; i++) begin
      measure(hi, hi_a);
      chk("start-up drive", 8'(PER), hi);
    end
    cycles(3 * PER);
    for (int i = 0; i < 7; i++) begin
      base = (i == 0) ? 20 : 25 + (i - 1) * STEP;
      set_temp(8'(base + ((i == 2) ? 0 : $urandom_range(3, 0))));
      repeat (3) measure(hi, hi_a);
      chk("duty", 8'((i + 4) * SLOT), hi);
      chk("auto duty", (i < 3) ? 8'h00 : 8'(PER), hi_a);
    end
    set_temp(8'h37);
    cycles(PER);
    exp_q.push_back(2'h2);
    set_temp(8'h38);
    repeat (2) measure(hi, hi_a);
    chk("overheat duty", 8'(PER), hi);
    set_temp(8'h33);
    cycles(PER);
    @(posedge mclk_in);
    req_n <= 1'b0;
    cycles(10);
    chk("shutdown drive", 8'h00, pwm);
    exp_q.push_back(2'h3);
    set_temp(8'h32);
    cycles(10);
    exp_q.push_back(2'h2);
    set_temp(8'h3C);
    cycles(10);
    exp_q.push_back(2'h3);
    set_temp(8'h14);
    cycles(10);
    exp_q.push_back(2'h1);
    @(posedge mclk_in);
    req_n <= 1'b1;
    stalled <= 1'b1;
    lim = 0;
    while (fault_n !== 1'b0 && lim < 140 * PER) begin
      @(negedge mclk_in);
      lim++;
    end
    if (lim >= 140 * PER) begin
      chk("fault wait", 8'h00, 8'h01);
      results();
    end
    chk("fault not early", 8'h01, 8'(lim > 100 * PER));
    chk("drive at fault", 8'h00, pwm);
    chk("auto fault", 8'h01, {7'h00, fault_a});
    // Auto variant sits in its fan-off state here; alert must still work
    exp_q.push_back(2'h0);
    set_temp(8'h3C);
    cycles(4);
    chk("auto overheat", 8'h00, {7'h00, ovh_a});
    exp_q.push_back(2'h1);
    set_temp(8'h14);
    cycles(4);
    cycles(2 * PER);
    chk("latched drive", 8'h00, pwm);
    exp_q.push_back(2'h3);
    @(posedge mclk_in);
    req_n <= 1'b0;
    cycles(10);
    chk("shutdown drive", 8'h00, pwm);
    @(posedge mclk_in);
    req_n <= 1'b1;
    stalled <= 1'b0;
    cycles(10);
    chk("restart drive", 8'h01, pwm);
    chk("pending alerts", 8'h00, 8'(exp_q.size()));
    results();
  end
endmodule
`default_nettype wire
